// [rtl/uart_ier_block.v]
// interrupt-enable logic and enhanced register bank of one uart channel
`timescale 1ns/1ns
`default_nettype none
`include "uart_ier_regs.vh"

module uart_ier_block (
  input  wire       clk,
  input  wire       rst_b,
  input  wire [2:0] addr,
  input  wire       cs_b,
  input  wire       rd_b,
  input  wire       wr_b,
  input  wire [7:0] wdata,
  output reg  [7:0] rdata,
  input  wire       rx_push,
  input  wire       rx_pop,
  input  wire       rx_head_parity,
  input  wire       rx_head_framing,
  input  wire       rx_head_break,
  input  wire       rx_any_error,
  input  wire       rx_overrun,
  input  wire [5:0] rx_level,
  input  wire [5:0] rx_trigger,
  input  wire       rx_timeout,
  input  wire       tx_holding_empty,
  input  wire       tx_below_trigger,
  input  wire       tx_shifter_empty,
  input  wire       msr_pending,
  input  wire       xoff_seen,
  input  wire       fifo_enable,
  output reg        irq,
  output reg        sleep_en,
  output reg        enh_en,
  output reg  [7:0] lcr_out,
  output reg  [7:0] mcr_out,
  output reg  [7:0] efr_out,
  output reg  [7:0] flow_resume_char_one_out,
  output reg  [7:0] flow_resume_char_two_out,
  output reg  [7:0] flow_pause_char_one_out,
  output reg  [7:0] flow_pause_char_two_out
);

  // ==========================================================
  // register storage
  reg  [7:0] ier_q;
  reg  [7:0] lcr_q;
  reg  [7:0] mcr_q;
  reg  [7:0] spr_q;
  reg  [7:0] dld_q;
  wire       dr_q;
  wire       oe_q;
  reg        tx_int_q;
  reg        tx_empty_d1_q;
  wire       xoff_int_q;
  wire [7:0] efr_q;
  wire [7:0] flow_resume_char_one_q;
  wire [7:0] flow_resume_char_two_q;
  wire [7:0] flow_pause_char_one_q;
  wire [7:0] flow_pause_char_two_q;

  wire wr_en  = ~cs_b & ~wr_b;
  wire rd_en  = ~cs_b & ~rd_b;
  wire enh_sp = (lcr_q == `LCR_ENH_KEY);
  wire dlab   = lcr_q[`LCR_DLAB_BIT];
  wire enh    = efr_q[`EFR_ENH_BIT];

  wire wr_ier = wr_en & ~dlab & (addr == `ADR_IER);
  wire rd_isr = rd_en & ~dlab & (addr == `ADR_ISR_FCR);
  wire rd_lsr = rd_en & ~enh_sp & ~dlab & (addr == `ADR_LSR);
  wire wr_enh = wr_en & enh_sp;

  // ==========================================================
  // enhanced bank
  // reachable only while the key value sits in line format
  byte_reg #(.RST_VAL(`RST_BYTE)) i_efr_reg (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (wr_enh & (addr == `ADR_EFR)),
    .din   (wdata),
    .dout  (efr_q)
  );
  byte_reg #(.RST_VAL(`RST_BYTE)) i_flow_resume_char_one_reg (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (wr_enh & (addr == `ADR_FLOW_RESUME_CHAR_ONE)),
    .din   (wdata),
    .dout  (flow_resume_char_one_q)
  );
  byte_reg #(.RST_VAL(`RST_BYTE)) i_flow_resume_char_two_reg (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (wr_enh & (addr == `ADR_FLOW_RESUME_CHAR_TWO)),
    .din   (wdata),
    .dout  (flow_resume_char_two_q)
  );
  byte_reg #(.RST_VAL(`RST_BYTE)) i_flow_pause_char_one_reg (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (wr_enh & (addr == `ADR_FLOW_PAUSE_CHAR_ONE)),
    .din   (wdata),
    .dout  (flow_pause_char_one_q)
  );
  byte_reg #(.RST_VAL(`RST_BYTE)) i_flow_pause_char_two_reg (
    .clk   (clk),
    .rst_b (rst_b),
    .we    (wr_enh & (addr == `ADR_FLOW_PAUSE_CHAR_TWO)),
    .din   (wdata),
    .dout  (flow_pause_char_two_q)
  );

  // ==========================================================
  // line status
  // data ready: level still counts the popped char here
  event_flag #(.RST_VAL(1'b0)) i_dr_flag (
    .clk   (clk),
    .rst_b (rst_b),
    .set   (rx_push),
    .clr   (rx_pop & (rx_level <= 6'h01)),
    .flag  (dr_q)
  );
  // overrun: set wins over the read clear
  event_flag #(.RST_VAL(1'b0)) i_oe_flag (
    .clk   (clk),
    .rst_b (rst_b),
    .set   (rx_overrun),
    .clr   (rd_lsr),
    .flag  (oe_q)
  );
  // xoff event, dropped by a status read
  event_flag #(.RST_VAL(1'b0)) i_xoff_flag (
    .clk   (clk),
    .rst_b (rst_b),
    .set   (xoff_seen),
    .clr   (rd_isr),
    .flag  (xoff_int_q)
  );
  wire [2:0] head_err = {rx_head_break, rx_head_framing, rx_head_parity};
  wire [7:0] line_state = {rx_any_error, tx_holding_empty & tx_shifter_empty,
                    tx_holding_empty, head_err, oe_q, dr_q};

  // ==========================================================
  // interrupt sources
  // receive data available
  wire rx_src = fifo_enable ? (rx_level >= rx_trigger) : dr_q;
  // overrun flag immediate, errors once at head
  wire ls_src = oe_q | (|head_err);
  wire tx_cond = fifo_enable ? tx_below_trigger : tx_holding_empty;
  wire rx_act = ier_q[`IER_RX_BIT] & rx_src;
  wire to_act = ier_q[`IER_RX_BIT] & rx_timeout;
  wire ls_act = ier_q[`IER_LS_BIT] & ls_src;
  wire tx_act = ier_q[`IER_TX_BIT] & tx_int_q;
  wire ms_act = ier_q[`IER_MS_BIT] & msr_pending;
  // xoff interrupt gated by enhanced enable
  wire xf_act = enh & ier_q[`IER_XOFF_BIT] & xoff_int_q;
  // with bits 0-3 and 5 clear nothing here fires
  wire any_act = rx_act | to_act | ls_act | tx_act | ms_act | xf_act;

  reg [7:0] interrupt_source_status;
  always @* begin
    // priority encode, bit 0 high when idle
    if (ls_act)
      interrupt_source_status = {4'h0, `ISR_LS};
    else if (to_act)
      interrupt_source_status = {4'h0, `ISR_RXTO};
    else if (rx_act)
      interrupt_source_status = {4'h0, `ISR_RX};
    else if (tx_act)
      interrupt_source_status = {4'h0, `ISR_TX};
    else if (ms_act)
      interrupt_source_status = {4'h0, `ISR_MS};
    else if (xf_act)
      interrupt_source_status = `ISR_XOFF;
    else
      interrupt_source_status = {4'h0, `ISR_NONE};
    if (fifo_enable)
      interrupt_source_status[7:6] = 2'b11;
  end

  // ==========================================================
  // register writes and event flags
  always @(posedge clk) begin
    if (!rst_b) begin
      ier_q         <= `RST_BYTE;
      lcr_q         <= `RST_BYTE;
      mcr_q         <= `RST_BYTE;
      spr_q         <= `RST_BYTE;
      dld_q         <= `RST_BYTE;
      tx_int_q      <= 1'b0;
      tx_empty_d1_q <= 1'b0;
    end else begin
      tx_empty_d1_q <= tx_cond;
      // edge into empty, or enable while already empty
      if (tx_cond & ~tx_empty_d1_q)
        tx_int_q <= 1'b1;
      else if (wr_ier & wdata[`IER_TX_BIT] & ~ier_q[`IER_TX_BIT] & tx_cond)
        tx_int_q <= 1'b1;
      else if ((rd_isr & tx_act & ~ls_act & ~to_act & ~rx_act) | ~tx_cond)
        tx_int_q <= 1'b0;
      if (wr_en) begin
        if (enh_sp) begin
          case (addr)
            `ADR_LCR:   lcr_q   <= wdata;
            default:    ;
          endcase
        end else begin
          case (addr)
            // upper enable bits held unless enhanced
            `ADR_IER: if (!dlab) begin
              ier_q <= enh ? wdata : ((ier_q & `IER_ENH_MASK) | (wdata & ~`IER_ENH_MASK));
            end
            `ADR_LCR: lcr_q <= wdata;
            `ADR_MCR: mcr_q <= enh ? wdata : {mcr_q[7:5], wdata[4:0]};
            `ADR_SPR: spr_q <= wdata;
            // fractional divisor only with enhanced set
            `ADR_ISR_FCR: if (dlab && enh) dld_q <= wdata;
            default:  ;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // registered outputs
  always @(posedge clk) begin
    if (!rst_b) begin
      rdata     <= `RST_BYTE;
      irq       <= 1'b0;
      sleep_en  <= 1'b0;
      enh_en    <= 1'b0;
      lcr_out   <= `RST_BYTE;
      mcr_out   <= `RST_BYTE;
      efr_out   <= `RST_BYTE;
      flow_resume_char_one_out  <= `RST_BYTE;
      flow_resume_char_two_out  <= `RST_BYTE;
      flow_pause_char_one_out <= `RST_BYTE;
      flow_pause_char_two_out <= `RST_BYTE;
    end else begin
      irq       <= any_act;
      sleep_en  <= enh & ier_q[`IER_SLEEP_BIT];
      enh_en    <= enh;
      lcr_out   <= lcr_q;
      mcr_out   <= enh ? mcr_q : {3'h0, mcr_q[4:0]};
      efr_out   <= efr_q;
      flow_resume_char_one_out  <= flow_resume_char_one_q;
      flow_resume_char_two_out  <= flow_resume_char_two_q;
      flow_pause_char_one_out <= flow_pause_char_one_q;
      flow_pause_char_two_out <= flow_pause_char_two_q;
      rdata     <= `RST_BYTE;
      if (rd_en) begin
        if (enh_sp) begin
          case (addr)
            `ADR_EFR:   rdata <= efr_q;
            `ADR_LCR:   rdata <= lcr_q;
            `ADR_FLOW_RESUME_CHAR_ONE:  rdata <= flow_resume_char_one_q;
            `ADR_FLOW_RESUME_CHAR_TWO:  rdata <= flow_resume_char_two_q;
            `ADR_FLOW_PAUSE_CHAR_ONE: rdata <= flow_pause_char_one_q;
            `ADR_FLOW_PAUSE_CHAR_TWO: rdata <= flow_pause_char_two_q;
            default:    rdata <= `RST_BYTE;
          endcase
        end else begin
          case (addr)
            `ADR_IER:     rdata <= enh ? ier_q : (ier_q & ~`IER_ENH_MASK);
            `ADR_ISR_FCR: rdata <= dlab ? (enh ? dld_q : 8'h00) : (enh ? interrupt_source_status : (interrupt_source_status & 8'hcf));
            `ADR_LCR:     rdata <= lcr_q;
            `ADR_MCR:     rdata <= enh ? mcr_q : {3'h0, mcr_q[4:0]};
            `ADR_LSR:     rdata <= line_state;
            `ADR_SPR:     rdata <= spr_q;
            default:      rdata <= `RST_BYTE;
          endcase
        end
      end
    end
  end

endmodule // uart_ier_block

// ==========================================================
// event flag, set wins over clear in the same cycle
module event_flag #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input  wire clk,
  input  wire rst_b,
  input  wire set,
  input  wire clr,
  output reg  flag
);
  always @(posedge clk) begin
    if (!rst_b)
      flag <= RST_VAL;
    else if (set)
      flag <= 1'b1;
    else if (clr)
      flag <= 1'b0;
  end
endmodule // event_flag

// ==========================================================
// byte register with write enable
module byte_reg #(
  parameter [7:0] RST_VAL = 8'h00
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       we,
  input  wire [7:0] din,
  output reg  [7:0] dout
);
  always @(posedge clk) begin
    if (!rst_b)
      dout <= RST_VAL;
    else if (we)
      dout <= din;
  end
endmodule // byte_reg
`default_nettype wire

// [inc/uart_ier_regs.vh]
// register offsets, bit positions and reset values for the channel register bank
`ifndef UART_IER_REGS_VH
`define UART_IER_REGS_VH
`define ADR_RX_TX        3'h0
`define ADR_IER          3'h1
`define ADR_ISR_FCR      3'h2
`define ADR_LCR          3'h3
`define ADR_MCR          3'h4
`define ADR_LSR          3'h5
`define ADR_MSR          3'h6
`define ADR_SPR          3'h7
`define ADR_EFR          3'h2
`define ADR_FLOW_RESUME_CHAR_ONE         3'h4
`define ADR_FLOW_RESUME_CHAR_TWO         3'h5
`define ADR_FLOW_PAUSE_CHAR_ONE        3'h6
`define ADR_FLOW_PAUSE_CHAR_TWO        3'h7
`define LCR_ENH_KEY      8'hbf
`define LCR_DLAB_BIT     7
`define EFR_ENH_BIT      4
`define IER_RX_BIT       0
`define IER_TX_BIT       1
`define IER_LS_BIT       2
`define IER_MS_BIT       3
`define IER_SLEEP_BIT    4
`define IER_XOFF_BIT     5
`define IER_ENH_MASK     8'hf0
`define RST_BYTE         8'h00
`define RST_ISR          8'h01
`define ISR_LS           4'h6
`define ISR_RXTO         4'hc
`define ISR_RX           4'h4
`define ISR_TX           4'h2
`define ISR_MS           4'h0
`define ISR_NONE         4'h1
`define ISR_XOFF         8'h10
`define FIFO_DEPTH_W     6
`endif

// [sim/uart_ier_props.sv]
// assertions on the channel register bank ports
`timescale 1ns/1ns
`default_nettype none
module uart_ier_props (
  input wire       clk,
  input wire       rst_b,
  input wire [2:0] addr,
  input wire       cs_b,
  input wire       rd_b,
  input wire       wr_b,
  input wire [7:0] wdata,
  input wire [7:0] rdata,
  input wire       rx_head_parity,
  input wire       rx_head_framing,
  input wire       rx_head_break,
  input wire       rx_any_error,
  input wire       tx_holding_empty,
  input wire       tx_shifter_empty,
  input wire       irq,
  input wire       sleep_en,
  input wire       enh_en,
  input wire [7:0] lcr_out,
  input wire [7:0] mcr_out,
  input wire [7:0] flow_resume_char_one_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ====================
  // sequences
  sequence lsr_rd;
    !cs_b && !rd_b && addr == 3'h5 && !lcr_out[7];
  endsequence
  sequence wr_cyc;
    !cs_b && !wr_b;
  endsequence
  a_reset_clears: assert property ($rose(rst_b) |->
    (lcr_out == 8'h00 && mcr_out == 8'h00) ##0 (!irq && !sleep_en && !enh_en) [*2])
    else $error("outputs not clear after reset");
  a_sleep_gated: assert property (sleep_en |-> enh_en || $past(enh_en))
    else $error("sleep without enhanced mode");
  a_mcr_gated: assert property (!enh_en && !$past(enh_en) |-> mcr_out[7:5] == 3'h0)
    else $error("modem setup high bits live");
  a_rdata_quiet: assert property (rdata != 8'h00 |-> !$past(cs_b) && !$past(rd_b))
    else $error("read data without read");
  a_tx_status: assert property (lsr_rd ##0 ($stable(tx_holding_empty)
    && $stable(tx_shifter_empty) && $stable(rx_any_error)) |=> rdata[7:5] ==
    {$past(rx_any_error), $past(tx_holding_empty) && $past(tx_shifter_empty),
    $past(tx_holding_empty)}) else $error("line state high bits wrong");
  a_err_status: assert property (lsr_rd ##0 ($stable(rx_head_parity)
    && $stable(rx_head_framing) && $stable(rx_head_break)) |=> rdata[4:2] ==
    {$past(rx_head_break), $past(rx_head_framing), $past(rx_head_parity)})
    else $error("line state error bits wrong");
  a_xon_write: assert property (wr_cyc ##0 (addr == 3'h4 && lcr_out == 8'hbf)
    |=> ##1 flow_resume_char_one_out == $past(wdata, 2)) else $error("resume char not written");
  a_lcr_write: assert property (wr_cyc ##0 addr == 3'h3 |=> ##1 lcr_out == $past(wdata, 2))
    else $error("line format not written");
endmodule // uart_ier_props
bind uart_ier_block uart_ier_props i_uart_ier_props (.clk(clk), .rst_b(rst_b),
  .addr(addr), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .wdata(wdata), .rdata(rdata),
  .rx_head_parity(rx_head_parity), .rx_head_framing(rx_head_framing),
  .rx_head_break(rx_head_break), .rx_any_error(rx_any_error),
  .tx_holding_empty(tx_holding_empty), .tx_shifter_empty(tx_shifter_empty),
  .irq(irq), .sleep_en(sleep_en), .enh_en(enh_en), .lcr_out(lcr_out),
  .mcr_out(mcr_out), .flow_resume_char_one_out(flow_resume_char_one_out));
`default_nettype wire

// [sim/rx_fifo_model.sv]
// receive side model: character moves and fifo fill count
`timescale 1ns/1ns
`default_nettype none
module rx_fifo_model (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       put,
  input  wire       take,
  output logic      rx_push,
  output logic      rx_pop,
  output logic[5:0] rx_level
);
  always @(posedge clk) begin
    rx_push <= put && rst_b;
    rx_pop <= take && rst_b && rx_level != 6'h00;
    if (!rst_b)
      rx_level <= 6'h00;
    // level moves after the pulse, so a pop still sees the old count
    else if (rx_push)
      rx_level <= rx_level + 6'h01;
    else if (rx_pop)
      rx_level <= rx_level - 6'h01;
  end
endmodule // rx_fifo_model
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the channel register bank
`timescale 1ns/1ns
`default_nettype none
`include "uart_ier_regs.vh"
module tb;
  logic       clk, rst_b, cs_b, rd_b, wr_b, put, take, the, tse, msr, fifo_en, any, ovr, tbt;
  logic       irq, sleep_en, push, pop, rd_taken, enh_o;
  logic [7:0] efr_o, xo[4:7];
  logic [2:0] addr, err;
  logic [7:0] wdata, rdata, v, e;
  logic [5:0] level, trig;
  logic [7:0] exp_q[$];
  int         checks, miscompares, seed, i;
  rx_fifo_model i_rx_fifo_model (.clk(clk), .rst_b(rst_b), .put(put), .take(take),
    .rx_push(push), .rx_pop(pop), .rx_level(level));
  uart_ier_block i_uart_ier_block (.clk(clk), .rst_b(rst_b), .addr(addr), .cs_b(cs_b),
    .rd_b(rd_b), .wr_b(wr_b), .wdata(wdata), .rdata(rdata), .rx_push(push), .rx_pop(pop),
    .rx_head_parity(err[0]), .rx_head_framing(err[1]), .rx_head_break(err[2]),
    .rx_any_error(any), .rx_overrun(ovr), .rx_level(level), .rx_trigger(trig),
    .rx_timeout(1'b0), .tx_holding_empty(the), .tx_below_trigger(tbt),
    .tx_shifter_empty(tse), .msr_pending(msr), .xoff_seen(1'b0), .fifo_enable(fifo_en),
    .irq(irq), .sleep_en(sleep_en), .enh_en(enh_o), .lcr_out(), .mcr_out(), .efr_out(efr_o),
    .flow_resume_char_one_out(xo[4]), .flow_resume_char_two_out(xo[5]), .flow_pause_char_one_out(xo[6]), .flow_pause_char_two_out(xo[7]));
  // ====================
  // tasks
  task check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    {cs_b, wr_b, addr, wdata} <= {2'b00, a, d};
    @(posedge clk);
    {cs_b, wr_b} <= 2'b11;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] x);
    @(posedge clk);
    {cs_b, rd_b, addr} <= {2'b00, a};
    @(posedge clk);
    {cs_b, rd_b} <= 2'b11;
    exp_q.push_back(x);
  endtask
  // irq is a registered level, so let the cause settle first
  task irq_is(input logic x);
    repeat (4) @(negedge clk);
    check({7'h00, irq}, {7'h00, x});
  endtask
  task rx(input logic p);
    @(posedge clk);
    {put, take} <= {p, !p};
    @(posedge clk);
    {put, take} <= 2'b00;
  endtask
  task print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ====================
  // clock, read monitor, watchdog
  initial begin
    clk = 1'b0;
    forever #50 clk = !clk;
  end
  always @(posedge clk) rd_taken <= !cs_b && !rd_b;
  always @(negedge clk) begin
    if (rd_taken) begin
      e = exp_q.pop_front();
      check(rdata, e);
    end
  end
  initial begin
    #400000;
    miscompares++;
    print_verdict;
  end
  // ====================
  // scenarios
  initial begin
    {rst_b, put, take, msr, fifo_en, any, the, tse, ovr, tbt} = 10'h00c;
    {cs_b, rd_b, wr_b, addr, err, wdata} = 17'h1c000;
    {trig, rd_taken, checks, miscompares, seed} = {6'h02, 1'b0, 32'd0, 32'd0, 32'd88939};
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(`ADR_IER, `RST_BYTE);
    rd(`ADR_ISR_FCR, `RST_ISR);
    rd(`ADR_LSR, 8'h60);
    $display("test reset values done");
    wr(`ADR_IER, 8'hff);
    irq_is(1'b1);
    check({7'h00, sleep_en}, 8'h00);
    rd(`ADR_IER, 8'h0f);
    rd(`ADR_ISR_FCR, 8'h02);
    irq_is(1'b0);
    $display("test transmit ready done");
    wr(`ADR_LCR, `LCR_ENH_KEY);
    wr(`ADR_EFR, 8'h10);
    rd(`ADR_EFR, 8'h10);
    check(efr_o, 8'h10);
    check({7'h00, enh_o}, 8'h01);
    for (i = 4; i < 8; i++) begin
      v = 8'($random(seed));
      wr(i[2:0], v);
      rd(i[2:0], v);
      check(xo[i], v);
    end
    wr(`ADR_LCR, 8'h00);
    wr(`ADR_IER, 8'h10);
    irq_is(1'b0);
    check({7'h00, sleep_en}, 8'h01);
    wr(`ADR_IER, 8'h20);
    rd(`ADR_IER, 8'h20);
    wr(`ADR_MCR, 8'he0);
    rd(`ADR_MCR, 8'he0);
    wr(`ADR_LCR, `LCR_ENH_KEY);
    wr(`ADR_EFR, 8'h00);
    wr(`ADR_LCR, 8'h00);
    rd(`ADR_IER, 8'h00);
    rd(`ADR_MCR, 8'h00);
    $display("test enhanced gating done");
    @(posedge clk) fifo_en <= 1'b1;
    wr(`ADR_IER, 8'h01);
    rx(1'b1);
    irq_is(1'b0);
    rd(`ADR_LSR, 8'h61);
    rx(1'b1);
    irq_is(1'b1);
    rd(`ADR_ISR_FCR, 8'hc4);
    rx(1'b0);
    irq_is(1'b0);
    rd(`ADR_LSR, 8'h61);
    rx(1'b0);
    rd(`ADR_LSR, 8'h60);
    $display("test receive trigger done");
    wr(`ADR_IER, 8'h00);
    for (i = 0; i < 3; i++) begin
      @(posedge clk) {any, err} <= {1'b1, 3'h1 << i};
      irq_is(1'b0);
      rd(`ADR_LSR, 8'he0 | (8'h04 << i));
    end
    wr(`ADR_IER, 8'h04);
    irq_is(1'b1);
    @(posedge clk) {any, err} <= 4'h0;
    irq_is(1'b0);
    @(posedge clk) ovr <= 1'b1;
    @(posedge clk) ovr <= 1'b0;
    irq_is(1'b1);
    rd(`ADR_LSR, 8'h62);
    irq_is(1'b0);
    $display("test line status done");
    wr(`ADR_IER, 8'h08);
    @(posedge clk) msr <= 1'b1;
    irq_is(1'b1);
    wr(`ADR_IER, 8'h00);
    irq_is(1'b0);
    wr(`ADR_IER, 8'h02);
    irq_is(1'b0);
    @(posedge clk) tbt <= 1'b1;
    irq_is(1'b1);
    rd(`ADR_ISR_FCR, 8'hc2);
    irq_is(1'b0);
    @(posedge clk) tse <= 1'b0;
    rd(`ADR_LSR, 8'h20);
    repeat (3) @(posedge clk);
    $display("test modem and transmit status done");
    print_verdict;
  end
endmodule // tb
`default_nettype wire
